// file: rtl/rip_pkg.sv
// Constants for the reset and interrupt priority unit.
// Assumes a 32-bit APB master and a CPU core that fetches vectors.
package rip_pkg;
    // Register byte offsets.
    localparam logic [7:0] OFS_FLAGS = 8'h00;
    localparam logic [7:0] OFS_PRIO = 8'h04;
    localparam logic [7:0] OFS_MEMMAP = 8'h08;
    localparam logic [7:0] OFS_OPTION = 8'h0C;
    localparam logic [7:0] OFS_TCTRL = 8'h10;
    localparam logic [7:0] OFS_TCOUNT = 8'h14;
    localparam logic [7:0] OFS_TFLAGS = 8'h18;
    localparam logic [7:0] OFS_CMP_BASE = 8'h1C;
    localparam logic [7:0] OFS_SBAUD = 8'h30;
    localparam logic [7:0] OFS_SCTRL = 8'h34;
    localparam logic [7:0] OFS_SSTAT = 8'h38;
    localparam logic [7:0] OFS_STATUS = 8'h3C;
    // Condition flag positions.
    localparam int FLG_I = 4;
    localparam int FLG_X = 6;
    localparam int FLG_S = 7;
    // Priority register field positions.
    localparam int PR_BOOT = 7;
    localparam int PR_SPECIAL_MODE_FLAG = 6;
    localparam int PR_MDA = 5;
    localparam int PR_VIS = 4;
    // Option register field positions.
    localparam int OP_IRQ_EDGE = 0;
    localparam int OP_OSC_DLY = 1;
    localparam int OP_CLKMON = 2;
    localparam int OP_RATE_LO = 4;
    // Reset values.
    localparam logic [2:0] RST_FLAGS = 3'h7;
    localparam logic [3:0] RST_PROMOTE = 4'h6;
    localparam logic [7:0] RST_MEMMAP = 8'h01;
    localparam logic [15:0] RST_TCOUNT = 16'h0000;
    localparam logic [15:0] RST_CMP = 16'hFFFF;
    localparam logic [7:0] RST_SBAUD = 8'h04;
    localparam logic [7:0] RST_SSTAT = 8'hC0;
    localparam logic [1:0] RST_RATE = 2'h0;
    // Vector addresses.
    localparam logic [15:0] VEC_RST_NORMAL = 16'hFFFE;
    localparam logic [15:0] VEC_RST_SPECIAL = 16'hBFFE;
    localparam logic [15:0] VEC_NMI = 16'hFFF4;
    localparam logic [15:0] VEC_SWTRAP = 16'hFFF6;
    localparam logic [15:0] VEC_ILLEGAL = 16'hFFF8;
    localparam logic [15:0] VEC_MASK_TOP = 16'hFFF2;
    // Sources and timing.
    localparam int NUM_MASK = 15;
    localparam int NUM_TMR = 9;
    localparam int NUM_CMP = 5;
    localparam int FETCH_CYCLES = 3;
    typedef enum logic [1:0] {ST_CAPTURE, ST_FETCH, ST_RUN} rip_state_t;
endpackage : rip_pkg

// file: rtl/rip_unit.sv
// Reset vector selection, reset initial states and interrupt priority resolution.
// Assumes APB and requests synchronous to i_ref_clk.
//
// Notes on behaviour
// R01 - Normal modes: reset vector FFFE, FFFC or FFFA by cause.
// R02 - Special modes: same three reset vectors relocated to BFFE, BFFC, BFFA.
// R03 - After reset release, restart vector is presented within three cycles, then run.
// R04 - Reset sets both interrupt mask flags and the stop-disable flag.
// R05 - Reset loads memory map register with 0x01.
// R06 - Reset clears timer count and prescaler, loads compares with all ones.
// R07 - Reset clears timer overflow, eight function flags and nine timer enables.
// R08 - Reset selects shortest watchdog rate; watchdog active only when disable bit clear.
// R09 - Reset loads serial rate 0x04, 8-bit characters, all serial functions disabled.
// R10 - After reset both transmit-empty flags read set, receive flags clear.
// R11 - Reset loads promotion field with 0110, external request highest.
// R12 - Reset selects level-sensitive detection for the external request pin.
// R13 - Mode pins are captured at reset release into boot, special and mode-A bits.
// R14 - In special modes, writes to special and mode-A bits change mode.
// R15 - Reset sets oscillator startup delay and clears clock monitor enable.
// R16 - Non-maskable order: pin, clock monitor, watchdog, request pin, illegal, trap.
// R17 - Default maskable order from external request down to asynchronous serial.
// R18 - Promotion code raises one maskable source; others keep their order.
// R19 - Promoted source remains blocked by global mask and local enables.
// R20 - Promotion changes order only; vectors stay fixed per source.
// R21 - Priority register writes accepted only while the global mask flag is set.
// R22 - Promotion codes: 0110 external, 0111 periodic, 0101 acts as external.
// R23 - Each cycle present the highest unmasked pending request, or none.
//
// Decided for this implementation: the address map and the APB interface to the registers.
module rip_unit (
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_mode_select_pin_a,
    input wire logic i_mode_select_pin_b,
    input wire logic i_watchdog_disable,
    input wire logic [1:0] i_reset_cause,
    input wire logic [2:0] i_reset_req,
    input wire logic i_nonmaskable_request_pin,
    input wire logic i_illegal_opcode,
    input wire logic i_software_trap,
    input wire logic [14:0] i_mask_req,
    input wire logic [3:0] i_capture_event,
    input wire logic [7:0] i_serial_status,
    output logic [15:0] o_vector,
    output logic o_vector_valid,
    output logic o_vector_is_reset,
    output logic o_restart,
    output logic o_cpu_run,
    output logic o_watchdog_active,
    output logic o_clock_monitor_enable,
    output logic o_oscillator_startup_delay,
    output logic o_irq_edge_mode
);
    rip_pkg::rip_state_t state_ff;
    logic [1:0] fetch_cnt_ff;
    logic [1:0] cause_ff;
    logic [2:0] flags_ff;
    logic boot_ff;
    logic special_mode_flag_ff;
    logic mda_ff;
    logic vis_ff;
    logic [3:0] promote_ff;
    logic [7:0] memmap_ff;
    logic [7:0] option_ff;
    logic [1:0] prescale_ff;
    logic [8:0] tmr_en_ff;
    logic [8:0] tmr_flag_ff;
    logic [15:0] tcount_ff;
    logic [3:0] pre_cnt_ff;
    logic [15:0] cmp_ff [rip_pkg::NUM_CMP];
    logic [7:0] sbaud_ff;
    logic [7:0] sctrl_ff;
    logic [7:0] sstat_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [15:0] vec_ff;
    logic vec_valid_ff;
    logic vec_reset_ff;
    logic restart_ff;
    logic run_ff;
    logic wd_active_ff;
    logic setup;
    logic wr_en;
    logic tick;
    logic [8:0] tmr_set;
    logic [14:0] pending;
    logic [2:0] rst_pending;
    logic [15:0] nxt_vec;
    logic nxt_valid;
    logic nxt_is_reset;
    logic [31:0] nxt_prdata;
    logic nxt_slverr;

    // Promotion code to default-order index.
    function automatic logic [3:0] promote_index(input logic [3:0] code);
        logic [3:0] idx;
        idx = 4'h0;
        if (code == 4'h7) begin
            idx = 4'h1; // R22
        end else if (code[3]) begin
            idx = 4'(code - 4'h6);
        end else if (code <= 4'h4) begin
            idx = 4'(code + 4'hA);
        end
        return idx;
    endfunction : promote_index

    // Fixed vector of a maskable source.
    function automatic logic [15:0] mask_vector(input logic [3:0] idx);
        return 16'(rip_pkg::VEC_MASK_TOP - {11'h000, idx, 1'b0}); // R20
    endfunction : mask_vector

    // Reset vector chosen by cause and mode.
    function automatic logic [15:0] reset_vector(input logic [1:0] cause, input logic special);
        logic [15:0] base;
        base = special ? rip_pkg::VEC_RST_SPECIAL : rip_pkg::VEC_RST_NORMAL; // R02
        return 16'(base - {13'h0000, cause, 1'b0}); // R01
    endfunction : reset_vector

    assign setup = i_psel && !i_penable;
    assign wr_en = i_psel && i_penable && pready_ff && i_pwrite;

    // Restart sequence: capture straps, present restart vector, then run.
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_ff <= rip_pkg::ST_CAPTURE;
            fetch_cnt_ff <= 2'h0;
            cause_ff <= 2'h0;
        end else begin
            case (state_ff)
                rip_pkg::ST_CAPTURE: begin
                    cause_ff <= (i_reset_cause == 2'h3) ? 2'h0 : i_reset_cause;
                    state_ff <= rip_pkg::ST_FETCH;
                end
                rip_pkg::ST_FETCH: begin
                    fetch_cnt_ff <= 2'(fetch_cnt_ff + 2'h1);
                    if (fetch_cnt_ff == 2'(rip_pkg::FETCH_CYCLES - 2)) begin
                        state_ff <= rip_pkg::ST_RUN; // R03
                    end
                end
                default: begin
                    state_ff <= rip_pkg::ST_RUN;
                end
            endcase
        end
    end

    // Condition flags.
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            flags_ff <= rip_pkg::RST_FLAGS; // R04
        end else if (wr_en && i_paddr == rip_pkg::OFS_FLAGS) begin
            flags_ff <= {i_pwdata[rip_pkg::FLG_S], i_pwdata[rip_pkg::FLG_X], i_pwdata[rip_pkg::FLG_I]};
        end
    end

    // Priority and mode register.
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            boot_ff <= 1'b0;
            special_mode_flag_ff <= 1'b0;
            mda_ff <= 1'b0;
            vis_ff <= 1'b0;
            promote_ff <= rip_pkg::RST_PROMOTE; // R11
        end else if (state_ff == rip_pkg::ST_CAPTURE) begin
            special_mode_flag_ff <= !i_mode_select_pin_b; // R13
            mda_ff <= i_mode_select_pin_a;
            boot_ff <= !i_mode_select_pin_b && !i_mode_select_pin_a;
            vis_ff <= !i_mode_select_pin_b && i_mode_select_pin_a;
        end else if (wr_en && i_paddr == rip_pkg::OFS_PRIO && flags_ff[0]) begin // R21
            promote_ff <= i_pwdata[3:0];
            vis_ff <= i_pwdata[rip_pkg::PR_VIS];
            if (special_mode_flag_ff) begin
                special_mode_flag_ff <= i_pwdata[rip_pkg::PR_SPECIAL_MODE_FLAG]; // R14
                mda_ff <= i_pwdata[rip_pkg::PR_MDA];
                boot_ff <= i_pwdata[rip_pkg::PR_BOOT] && i_pwdata[rip_pkg::PR_SPECIAL_MODE_FLAG];
            end
        end
    end

    // Memory map and option registers.
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            memmap_ff <= rip_pkg::RST_MEMMAP; // R05
            option_ff <= 8'h02; // R15
        end else if (wr_en && i_paddr == rip_pkg::OFS_MEMMAP) begin
            memmap_ff <= i_pwdata[7:0];
        end else if (wr_en && i_paddr == rip_pkg::OFS_OPTION) begin
            option_ff <= {2'h0, i_pwdata[5:4], 1'b0, i_pwdata[2:0]};
        end
    end

    // Timer control.
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            prescale_ff <= 2'h0; // R06
            tmr_en_ff <= 9'h000; // R07
        end else if (wr_en && i_paddr == rip_pkg::OFS_TCTRL) begin
            prescale_ff <= i_pwdata[1:0];
            tmr_en_ff <= i_pwdata[24:16];
        end
    end

    // Prescaled free-running count.
    assign tick = (pre_cnt_ff & ((4'h1 << prescale_ff) - 4'h1)) == 4'h0;

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pre_cnt_ff <= 4'h0;
            tcount_ff <= rip_pkg::RST_TCOUNT; // R06
        end else begin
            pre_cnt_ff <= 4'(pre_cnt_ff + 4'h1);
            if (tick) begin
                tcount_ff <= 16'(tcount_ff + 16'h0001);
            end
        end
    end

    // Compare registers.
    for (genvar g = 0; g < rip_pkg::NUM_CMP; g++) begin : g_cmp
        always_ff @(posedge i_ref_clk or negedge i_resetn) begin
            if (!i_resetn) begin
                cmp_ff[g] <= rip_pkg::RST_CMP; // R06
            end else if (wr_en && i_paddr == 8'(rip_pkg::OFS_CMP_BASE + 8'(4 * g))) begin
                cmp_ff[g] <= i_pwdata[15:0];
            end
        end
    end

    // Timer flag events.
    always_comb begin
        tmr_set = 9'h000;
        tmr_set[2:0] = i_capture_event[2:0];
        for (int k = 0; k < 4; k++) begin
            tmr_set[3 + k] = tick && (tcount_ff == cmp_ff[k]);
        end
        tmr_set[7] = i_capture_event[3] || (tick && tcount_ff == cmp_ff[4]);
        tmr_set[8] = tick && (tcount_ff == 16'hFFFF);
    end

    // Timer flags clear by writing ones; a new event wins over the clear.
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            tmr_flag_ff <= 9'h000; // R07
        end else if (wr_en && i_paddr == rip_pkg::OFS_TFLAGS) begin
            tmr_flag_ff <= (tmr_flag_ff & ~i_pwdata[8:0]) | tmr_set;
        end else begin
            tmr_flag_ff <= tmr_flag_ff | tmr_set;
        end
    end

    // Serial control and status.
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sbaud_ff <= rip_pkg::RST_SBAUD; // R09
            sctrl_ff <= 8'h00;
        end else if (wr_en && i_paddr == rip_pkg::OFS_SBAUD) begin
            sbaud_ff <= i_pwdata[7:0];
        end else if (wr_en && i_paddr == rip_pkg::OFS_SCTRL) begin
            sctrl_ff <= i_pwdata[7:0];
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sstat_ff <= rip_pkg::RST_SSTAT; // R10
        end else if (sctrl_ff[3] || sctrl_ff[2]) begin
            sstat_ff <= i_serial_status;
        end
    end

    // Watchdog enable.
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wd_active_ff <= 1'b0;
        end else begin
            wd_active_ff <= !i_watchdog_disable; // R08
        end
    end

    // Pending requests after global and local masking.
    always_comb begin
        pending = i_mask_req;
        pending[10:2] = tmr_flag_ff & tmr_en_ff; // R19
        if (flags_ff[0]) begin
            pending = 15'h0000; // R19
        end
        rst_pending = i_reset_req;
        rst_pending[1] = i_reset_req[1] && option_ff[rip_pkg::OP_CLKMON];
        rst_pending[2] = i_reset_req[2] && wd_active_ff;
    end

    // Priority resolution.
    always_comb begin
        logic [3:0] top;
        top = promote_index(promote_ff);
        nxt_vec = 16'h0000;
        nxt_valid = 1'b0;
        nxt_is_reset = 1'b0;
        if (state_ff != rip_pkg::ST_RUN) begin
            nxt_vec = reset_vector(cause_ff, special_mode_flag_ff);
            nxt_valid = 1'b1;
            nxt_is_reset = 1'b1;
        end else if (rst_pending != 3'h0) begin // R16
            nxt_is_reset = 1'b1;
            nxt_valid = 1'b1;
            if (rst_pending[0]) begin
                nxt_vec = reset_vector(2'h0, special_mode_flag_ff);
            end else if (rst_pending[1]) begin
                nxt_vec = reset_vector(2'h1, special_mode_flag_ff);
            end else begin
                nxt_vec = reset_vector(2'h2, special_mode_flag_ff);
            end
        end else if (i_nonmaskable_request_pin && !flags_ff[1]) begin
            nxt_vec = rip_pkg::VEC_NMI;
            nxt_valid = 1'b1;
        end else if (i_illegal_opcode) begin
            nxt_vec = rip_pkg::VEC_ILLEGAL;
            nxt_valid = 1'b1;
        end else if (i_software_trap) begin
            nxt_vec = rip_pkg::VEC_SWTRAP;
            nxt_valid = 1'b1;
        end else if (pending[top]) begin // R18
            nxt_vec = mask_vector(top);
            nxt_valid = 1'b1;
        end else begin
            for (int k = rip_pkg::NUM_MASK - 1; k >= 0; k--) begin
                if (pending[k]) begin // R17
                    nxt_vec = mask_vector(4'(k));
                    nxt_valid = 1'b1; // R23
                end
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            vec_ff <= 16'h0000;
            vec_valid_ff <= 1'b0;
            vec_reset_ff <= 1'b0;
            restart_ff <= 1'b0;
            run_ff <= 1'b0;
        end else begin
            vec_ff <= nxt_vec; // R23
            vec_valid_ff <= nxt_valid;
            vec_reset_ff <= nxt_is_reset;
            restart_ff <= state_ff != rip_pkg::ST_RUN; // R03
            run_ff <= state_ff == rip_pkg::ST_RUN;
        end
    end

    // Register read decode.
    always_comb begin
        nxt_prdata = 32'h0000_0000;
        nxt_slverr = 1'b0;
        if (i_paddr == rip_pkg::OFS_FLAGS) begin
            nxt_prdata[rip_pkg::FLG_S] = flags_ff[2];
            nxt_prdata[rip_pkg::FLG_X] = flags_ff[1];
            nxt_prdata[rip_pkg::FLG_I] = flags_ff[0];
        end else if (i_paddr == rip_pkg::OFS_PRIO) begin
            nxt_prdata[7:0] = {boot_ff, special_mode_flag_ff, mda_ff, vis_ff, promote_ff};
        end else if (i_paddr == rip_pkg::OFS_MEMMAP) begin
            nxt_prdata[7:0] = memmap_ff;
        end else if (i_paddr == rip_pkg::OFS_OPTION) begin
            nxt_prdata[7:0] = option_ff;
        end else if (i_paddr == rip_pkg::OFS_TCTRL) begin
            nxt_prdata[24:16] = tmr_en_ff;
            nxt_prdata[1:0] = prescale_ff;
        end else if (i_paddr == rip_pkg::OFS_TCOUNT) begin
            nxt_prdata[15:0] = tcount_ff;
        end else if (i_paddr == rip_pkg::OFS_TFLAGS) begin
            nxt_prdata[8:0] = tmr_flag_ff;
        end else if (i_paddr >= rip_pkg::OFS_CMP_BASE && i_paddr < rip_pkg::OFS_SBAUD && i_paddr[1:0] == 2'h0) begin
            nxt_prdata[15:0] = cmp_ff[3'(8'(i_paddr - rip_pkg::OFS_CMP_BASE) >> 2)];
        end else if (i_paddr == rip_pkg::OFS_SBAUD) begin
            nxt_prdata[7:0] = sbaud_ff;
        end else if (i_paddr == rip_pkg::OFS_SCTRL) begin
            nxt_prdata[7:0] = sctrl_ff;
        end else if (i_paddr == rip_pkg::OFS_SSTAT) begin
            nxt_prdata[7:0] = sstat_ff;
        end else if (i_paddr == rip_pkg::OFS_STATUS) begin
            nxt_prdata[15:0] = vec_ff;
            nxt_prdata[16] = vec_valid_ff;
            nxt_prdata[18:17] = cause_ff;
            nxt_prdata[19] = run_ff;
            nxt_prdata[20] = wd_active_ff;
        end else begin
            nxt_slverr = 1'b1;
        end
    end

    // Answer in the cycle after setup.
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else begin
            pready_ff <= setup;
            pslverr_ff <= setup && nxt_slverr;
            if (setup && !i_pwrite) begin
                prdata_ff <= nxt_prdata;
            end
        end
    end

    assign o_prdata = prdata_ff;
    assign o_pready = pready_ff;
    assign o_pslverr = pslverr_ff;
    assign o_vector = vec_ff;
    assign o_vector_valid = vec_valid_ff;
    assign o_vector_is_reset = vec_reset_ff;
    assign o_restart = restart_ff;
    assign o_cpu_run = run_ff;
    assign o_watchdog_active = wd_active_ff;
    assign o_clock_monitor_enable = option_ff[rip_pkg::OP_CLKMON];
    assign o_oscillator_startup_delay = option_ff[rip_pkg::OP_OSC_DLY];
    assign o_irq_edge_mode = option_ff[rip_pkg::OP_IRQ_EDGE]; // R12
endmodule : rip_unit

// file: test/rip_unit_asserts.sv
// Port checks for the reset and interrupt priority unit.
// Bound to rip_unit; one clock, async active-low reset.
module rip_unit_chk (
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic i_watchdog_disable,
    input wire logic [2:0] i_reset_req,
    input wire logic i_nonmaskable_request_pin,
    input wire logic i_illegal_opcode,
    input wire logic i_software_trap,
    input wire logic [15:0] o_vector,
    input wire logic o_vector_valid,
    input wire logic o_restart,
    input wire logic o_cpu_run,
    input wire logic o_watchdog_active
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);
    property p_ready_after_setup; i_psel && !i_penable |=> o_pready; endproperty
    a_ready_after_setup: assert property (p_ready_after_setup) else $error("no ready after setup");
    property p_ready_pulse; o_pready |=> !o_pready; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");
    property p_err_with_ready; o_pslverr |-> o_pready; endproperty
    a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");
    property p_restart_len; $rose(o_restart) |-> o_restart [*3] ##1 (!o_restart && o_cpu_run); endproperty
    a_restart_len: assert property (p_restart_len) else $error("restart not three cycles");
    property p_reset_vec; o_restart && $past(o_restart) |-> o_vector inside {16'hFFFE, 16'hFFFC, 16'hFFFA,
        16'hBFFE, 16'hBFFC, 16'hBFFA}; endproperty
    a_reset_vec: assert property (p_reset_vec) else $error("bad restart vector");
    property p_watchdog; $past(i_resetn) |-> o_watchdog_active == !$past(i_watchdog_disable); endproperty
    a_watchdog: assert property (p_watchdog) else $error("watchdog wrong");
    property p_illegal; o_cpu_run && $past(o_cpu_run) && $past(i_illegal_opcode) && !$past(i_nonmaskable_request_pin)
        && !$past(|i_reset_req) |-> o_vector_valid && o_vector == 16'hFFF8; endproperty
    a_illegal: assert property (p_illegal) else $error("illegal vector wrong");
    property p_trap; o_cpu_run && $past(o_cpu_run) && $past(i_software_trap) && !$past(i_illegal_opcode)
        && !$past(i_nonmaskable_request_pin) && !$past(|i_reset_req) |-> o_vector == 16'hFFF6; endproperty
    a_trap: assert property (p_trap) else $error("trap vector wrong");
endmodule : rip_unit_chk

bind rip_unit rip_unit_chk u_chk (.*);

// file: test/rip_cpu_model.sv
// Behavioural processor core that fetches vectors from the priority unit.
// Uses the unit's clock and reset.
module rip_cpu_model (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_restart,
    input wire logic i_run,
    input wire logic [15:0] i_vector,
    input wire logic i_want_trap,
    input wire logic i_want_illegal,
    output logic o_trap,
    output logic o_illegal,
    output logic [15:0] o_fetched,
    output logic [3:0] o_fetch_cycles
);
    // Takes restart vectors; raises traps only when running.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_fetched <= 16'h0000;
            o_fetch_cycles <= 4'h0;
            o_trap <= 1'b0;
            o_illegal <= 1'b0;
        end else begin
            if (i_restart) begin
                o_fetched <= i_vector;
                o_fetch_cycles <= o_fetch_cycles + 4'h1;
            end
            o_trap <= i_run & i_want_trap;
            o_illegal <= i_run & i_want_illegal;
        end
    end
endmodule : rip_cpu_model

// file: test/tb.sv
// Self-checking bench for the reset and interrupt priority unit.
// Assumes rip_unit, its checker and rip_cpu_model.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, pready, pslverr, err, ill, trap, vvalid, run, restart;
    logic rstn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, pina = 1'b0, pinb = 1'b0, wdd = 1'b0, nmi = 1'b0;
    logic want_ill = 1'b0, want_trap = 1'b0;
    logic [1:0] cause = 2'h0;
    logic [2:0] rreq = 3'h0;
    logic [7:0] paddr = 8'h00, sstat = 8'h00;
    logic [14:0] mreq = 15'h0;
    logic [15:0] vec, cpu_vec;
    logic [3:0] cpu_cyc;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    int error_cnt = 0, checks_done = 0, cyc = 0;
    localparam logic [7:0] reg_addr [13] = '{8'h00, 8'h08, 8'h0C, 8'h10, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h28,
        8'h2C, 8'h30, 8'h34, 8'h38};
    localparam logic [31:0] reg_rst [13] = '{32'hD0, 32'h01, 32'h02, 32'h0, 32'h0, 32'hFFFF, 32'hFFFF,
        32'hFFFF, 32'hFFFF, 32'hFFFF, 32'h04, 32'h00, 32'hC0};
    rip_unit DUT (.i_ref_clk(clk), .i_resetn(rstn), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_mode_select_pin_a(pina), .i_mode_select_pin_b(pinb), .i_watchdog_disable(wdd), .i_reset_cause(cause),
        .i_reset_req(rreq), .i_nonmaskable_request_pin(nmi), .i_illegal_opcode(ill), .i_software_trap(trap),
        .i_mask_req(mreq), .i_capture_event(4'h0), .i_serial_status(sstat), .o_vector(vec),
        .o_vector_valid(vvalid), .o_vector_is_reset(), .o_restart(restart), .o_cpu_run(run),
        .o_watchdog_active(), .o_clock_monitor_enable(), .o_oscillator_startup_delay(), .o_irq_edge_mode());
    rip_cpu_model cpu (.i_clk(clk), .i_resetn(rstn), .i_restart(restart), .i_run(run), .i_vector(vec),
        .i_want_trap(want_trap), .i_want_illegal(want_ill), .o_trap(trap), .o_illegal(ill), .o_fetched(cpu_vec),
        .o_fetch_cycles(cpu_cyc));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task give_verdict();
        if (error_cnt == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : give_verdict
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            give_verdict();
        end
    end
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    task do_reset(input logic [1:0] pins, input logic [1:0] why);
        @(posedge clk);
        rstn <= 1'b0;
        pina <= pins[0];
        pinb <= pins[1];
        cause <= why;
        wdd <= 1'($urandom);
        sstat <= 8'($urandom);
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
    endtask : do_reset
    // Expected valid and vector per promotion code.
    function automatic logic [31:0] irq_expect(input logic [3:0] code, input logic [14:0] req);
        int p;
        int idx;
        p = code[3] ? int'(code) - 6 : (code == 4'h7 ? 1 : (code <= 4'h4 ? 10 + int'(code) : 0));
        idx = -1;
        for (int k = 14; k >= 0; k--) if (req[k]) idx = k;
        if (req[p]) idx = p;
        if (idx < 0) return 32'h0;
        return {15'h0, 1'b1, 16'hFFF2 - 16'(2 * idx)};
    endfunction : irq_expect
    initial begin
        logic [1:0] pins;
        logic sp;
        logic [3:0] code;
        logic [14:0] req;
        logic [31:0] exp;
        void'($urandom(75638));
        for (int i = 0; i < 6; i++) begin
            pins = 2'((i + 2) % 4);
            sp = ~pins[1];
            do_reset(pins, 2'(i % 3));
            repeat (6) @(posedge clk);
            check("restart vector", {16'h0, cpu_vec}, {16'h0, (sp ? 4'hB : 4'hF), 12'hFFE} - 32'(2 * (i % 3)));
            check("fetch cycles", {28'h0, cpu_cyc}, 32'h3);
            apb(1'b0, 8'h04, 32'h0);
            check("mode field", rd, {24'h0, sp & ~pins[0], sp, pins[0], sp & pins[0], 4'h6});
            apb(1'b1, 8'h04, {24'h0, 2'b01, ~pins[0], 5'h06});
            apb(1'b0, 8'h04, 32'h0);
            check("mode write", {30'h0, rd[6:5]}, {30'h0, sp, (sp ? ~pins[0] : pins[0])});
        end
        for (int k = 0; k < 13; k++) begin
            apb(1'b0, reg_addr[k], 32'h0);
            check("reset value", rd, reg_rst[k]);
        end
        apb(1'b1, 8'h40, 32'hFFFFFFFF);
        check("unmapped error", {31'h0, err}, 32'h1);
        want_ill <= 1'b1;
        want_trap <= 1'b1;
        repeat (3) @(posedge clk);
        #1 check("illegal first", {16'h0, vec}, 32'hFFF8);
        want_ill <= 1'b0;
        nmi <= 1'b1;
        rreq <= 3'h7;
        repeat (3) @(posedge clk);
        #1 check("reset request", {16'h0, vec}, 32'hFFFE);
        rreq <= 3'h0;
        repeat (3) @(posedge clk);
        #1 check("masked pin", {16'h0, vec}, 32'hFFF6);
        nmi <= 1'b0;
        want_trap <= 1'b0;
        for (int n = 0; n < 40; n++) begin
            code = (n < 7) ? 4'(n + 1) : 4'($urandom);
            req = (n < 7) ? 15'h7803 : 15'($urandom) & 15'h7803;
            apb(1'b1, 8'h00, 32'hD0);
            @(posedge clk);
            #1 check("masked request", {31'h0, vvalid}, 32'h0);
            apb(1'b1, 8'h04, {28'h0, code});
            apb(1'b1, 8'h00, 32'hC0);
            apb(1'b1, 8'h04, {28'h0, ~code});
            apb(1'b0, 8'h04, 32'h0);
            check("promotion field", {28'h0, rd[3:0]}, {28'h0, code});
            mreq <= req;
            repeat (2) @(posedge clk);
            #1 exp = irq_expect(code, req);
            check("request valid", {31'h0, vvalid}, {31'h0, exp[16]});
            if (exp[16]) check("request vector", {16'h0, vec}, {16'h0, exp[15:0]});
        end
        give_verdict();
    end
endmodule : tb
